// >>> hw/rfs_pkg.sv
package rfs_pkg;
    localparam logic [7:0] TRX_CTRL_ONE_ADDR = 8'h04;
    localparam logic [7:0] RF_CTRL_ZERO_ADDR = 8'h16;
    localparam int         EXT_AMP_EN_BIT    = 7;
    localparam int         LEAD_LO_BIT       = 0;
    localparam int         LEAD_HI_BIT       = 1;
    localparam logic [7:0] TRX_CTRL_ONE_RST  = 8'h00;
    localparam logic [7:0] RF_CTRL_ZERO_RST  = 8'h00;
    localparam logic [1:0] LEAD_MAX          = 2'h3;
    localparam logic [7:0] READ_BIT_MASK     = 8'h80;
    localparam int         SPI_BYTE_BITS     = 8;
    localparam logic [2:0] SPI_LAST_BIT      = 3'h7;
    localparam logic [2:0] BIT_CNT_ZERO      = 3'h0;

    typedef enum logic [1:0] {
        RFS_IDLE = 2'b00,
        RFS_ADDR = 2'b01,
        RFS_DATA = 2'b11,
        RFS_DONE = 2'b10
    } rfs_spi_state_t;

    typedef struct packed {
        logic tx_line;
        logic rx_line;
    } rfs_fe_t;
endpackage

// >>> hw/rfs_sync.sv
`timescale 1ns/1ps
module rfs_sync
    import rfs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // First stage feeds only the second stage
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// >>> hw/rfs_front_end.sv
`timescale 1ns/1ps
module rfs_front_end
    import rfs_pkg::*;
(
    input  wire logic REF_CLK_IN,
    input  wire logic RESET_N_IN,
    input  wire logic RADIO_TX_IN,
    input  wire logic RADIO_RX_IN,
    input  wire logic SPI_SCK_IN,
    input  wire logic SPI_CS_N_IN,
    input  wire logic SPI_MOSI_IN,
    output logic      SPI_MISO_OUT,
    output logic      FRONT_END_TX_LINE_OUT,
    output logic      FRONT_END_RX_LINE_OUT,
    output logic [1:0] AMP_LEAD_TIME_OUT
);
    // Pins are sampled into this clock through two flops
    // The stages reset low, so select reads active for two clocks after
    // reset; harmless, as SCK idles low and no bit can be taken then
    logic [2:0] pins_s;
    rfs_sync #(.WIDTH(3)) u_sync (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RESET_N_IN),
        .async_in ({SPI_SCK_IN, SPI_CS_N_IN, SPI_MOSI_IN}),
        .sync_out (pins_s)
    );
    logic sck_s, cs_n_s, mosi_s;
    assign sck_s  = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign mosi_s = pins_s[0];

    logic [1:0] radio_s;
    rfs_sync #(.WIDTH(2)) u_sync_radio (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RESET_N_IN),
        .async_in ({RADIO_TX_IN, RADIO_RX_IN}),
        .sync_out (radio_s)
    );

    // Every check below lives in this one clock domain
    default clocking cb_ref @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    logic           sck_d_ff;
    logic [7:0]     trx_ctrl_one_ff, rf_ctrl_zero_ff;
    logic [7:0]     sh_in_ff, sh_out_ff, addr_ff;
    logic [2:0]     bit_cnt_ff;
    logic           rd_ff;
    rfs_spi_state_t state_ff;
    rfs_fe_t        fe_ff;

    wire sck_rise = sck_s & ~sck_d_ff;
    wire sck_fall = ~sck_s & sck_d_ff;
    wire last_bit = (bit_cnt_ff == SPI_LAST_BIT);
    wire [7:0] shifted = {sh_in_ff[6:0], mosi_s};

    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [7:0] t,
                                            input logic [7:0] r);
        reg_read = (a == TRX_CTRL_ONE_ADDR) ? t :
                   (a == RF_CTRL_ZERO_ADDR) ? r : 8'h00;
    endfunction

    wire byte_done = sck_rise & last_bit;
    wire wr_strobe = byte_done & (state_ff == RFS_DATA) & ~rd_ff;
    wire [7:0] addr_next = shifted & ~READ_BIT_MASK;

    // Byte 1: read flag in msb plus address; byte 2: data
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sck_d_ff   <= 1'b0;
            state_ff   <= RFS_IDLE;
            bit_cnt_ff <= BIT_CNT_ZERO;
            sh_in_ff   <= 8'h00;
            sh_out_ff  <= 8'h00;
            addr_ff    <= 8'h00;
            rd_ff      <= 1'b0;
        end else begin
            sck_d_ff <= sck_s;
            if (cs_n_s) begin
                state_ff   <= RFS_IDLE;
                bit_cnt_ff <= BIT_CNT_ZERO;
            end else begin
                case (state_ff)
                    RFS_IDLE: begin
                        state_ff   <= RFS_ADDR;
                        bit_cnt_ff <= BIT_CNT_ZERO;
                    end
                    RFS_ADDR: begin
                        if (sck_rise) begin
                            sh_in_ff   <= shifted;
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        end
                        if (byte_done) begin
                            addr_ff   <= addr_next;
                            rd_ff     <= shifted[7];
                            sh_out_ff <= reg_read(addr_next,
                                trx_ctrl_one_ff, rf_ctrl_zero_ff);
                            state_ff  <= RFS_DATA;
                        end
                    end
                    RFS_DATA: begin
                        if (sck_rise) begin
                            sh_in_ff   <= shifted;
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        end
                        if (sck_fall && bit_cnt_ff != BIT_CNT_ZERO) begin
                            sh_out_ff <= {sh_out_ff[6:0], 1'b0};
                        end
                        if (byte_done) begin
                            state_ff <= RFS_DONE;
                        end
                    end
                    RFS_DONE: state_ff <= RFS_DONE;
                    default:  state_ff <= RFS_IDLE;
                endcase
            end
        end
    end

    assign SPI_MISO_OUT = sh_out_ff[7];

    // A deselect must always drop the frame, whatever state it is in
    cs_abort_a: assert property (
        cs_n_s |=> state_ff == RFS_IDLE && bit_cnt_ff == BIT_CNT_ZERO)
        else $error("frame not dropped on deselect");
    idle_cnt_a: assert property (
        state_ff == RFS_IDLE |-> bit_cnt_ff == BIT_CNT_ZERO)
        else $error("bit counter not cleared in idle");
    addr_hold_a: assert property (
        state_ff == RFS_DATA |=> $stable(addr_ff) && $stable(rd_ff))
        else $error("address moved during data byte");
    extra_byte_a: assert property (
        (state_ff == RFS_DONE && !cs_n_s) |=> state_ff == RFS_DONE)
        else $error("bytes after the second not ignored");
    miso_ctrl_a: assert property (
        (state_ff == RFS_ADDR && byte_done && shifted[7]
            && addr_next == TRX_CTRL_ONE_ADDR)
        |=> SPI_MISO_OUT == trx_ctrl_one_ff[$high(trx_ctrl_one_ff)])
        else $error("control read msb not loaded");
    miso_rf_a: assert property (
        (state_ff == RFS_ADDR && byte_done && shifted[7]
            && addr_next == RF_CTRL_ZERO_ADDR)
        |=> SPI_MISO_OUT == rf_ctrl_zero_ff[$high(rf_ctrl_zero_ff)])
        else $error("rf read msb not loaded");

    // Configuration registers, written only through SPI
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            trx_ctrl_one_ff <= TRX_CTRL_ONE_RST;
            rf_ctrl_zero_ff <= RF_CTRL_ZERO_RST;
        end else if (wr_strobe) begin
            if (addr_ff == TRX_CTRL_ONE_ADDR) trx_ctrl_one_ff <= shifted;
            if (addr_ff == RF_CTRL_ZERO_ADDR) rf_ctrl_zero_ff <= shifted;
        end
    end

    cfg_spi_a: assert property (
        $changed(trx_ctrl_one_ff) |-> $past(wr_strobe))
        else $error("register changed without SPI write");
    rf_spi_a: assert property (
        $changed(rf_ctrl_zero_ff) |-> $past(wr_strobe))
        else $error("rf register changed without SPI write");
    rd_no_wr_a: assert property (
        (byte_done && state_ff == RFS_DATA && rd_ff)
        |=> $stable(trx_ctrl_one_ff) && $stable(rf_ctrl_zero_ff))
        else $error("read frame wrote a register");
    amp_wr_a: assert property (
        (wr_strobe && addr_ff == TRX_CTRL_ONE_ADDR)
        |=> trx_ctrl_one_ff == $past(shifted))
        else $error("control write lost");

    // Lead time is exported; the host is expected to program the max
    assign AMP_LEAD_TIME_OUT = {rf_ctrl_zero_ff[LEAD_HI_BIT],
                                rf_ctrl_zero_ff[LEAD_LO_BIT]};

    wire amp_en = trx_ctrl_one_ff[EXT_AMP_EN_BIT];
    // Transmit wins if the radio reports both at once
    rfs_fe_t nxt_fe;
    wire     radio_tx_s = radio_s[1];
    wire     radio_rx_s = radio_s[0];
    assign nxt_fe = '{
        tx_line: amp_en & radio_tx_s,
        rx_line: amp_en & ~radio_tx_s & radio_rx_s
    };

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) fe_ff <= '0;
        else             fe_ff <= nxt_fe;
    end
    assign FRONT_END_TX_LINE_OUT = fe_ff.tx_line;
    assign FRONT_END_RX_LINE_OUT = fe_ff.rx_line;

    tx_drive_a: assert property (
        (amp_en && radio_tx_s)
        |=> FRONT_END_TX_LINE_OUT && !FRONT_END_RX_LINE_OUT)
        else $error("tx drive wrong");
    rx_drive_a: assert property (
        (amp_en && !radio_tx_s && radio_rx_s)
        |=> !FRONT_END_TX_LINE_OUT && FRONT_END_RX_LINE_OUT)
        else $error("rx drive wrong");
    amp_gate_a: assert property (
        !amp_en |=> !FRONT_END_TX_LINE_OUT && !FRONT_END_RX_LINE_OUT)
        else $error("lines driven while disabled");
    idle_low_a: assert property (
        (!radio_tx_s && !radio_rx_s)
        |=> !FRONT_END_TX_LINE_OUT && !FRONT_END_RX_LINE_OUT)
        else $error("idle lines high");
    fe_excl_a: assert property (
        !(FRONT_END_TX_LINE_OUT && FRONT_END_RX_LINE_OUT))
        else $error("both front-end lines high");

    lead_out_a: assert property (
        (wr_strobe && addr_ff == RF_CTRL_ZERO_ADDR)
        |=> AMP_LEAD_TIME_OUT == $past(shifted[LEAD_HI_BIT:LEAD_LO_BIT]))
        else $error("lead time not updated");
    lead_hold_a: assert property (
        !(wr_strobe && addr_ff == RF_CTRL_ZERO_ADDR)
        |=> $stable(AMP_LEAD_TIME_OUT))
        else $error("lead time moved without a write");
endmodule

// >>> tb/rfs_fe_model.sv
`timescale 1ns/1ps
module rfs_fe_model (
    input  wire logic tx_en_in,
    input  wire logic rx_en_in,
    output logic      pa_on_out,
    output logic      lna_on_out
);
    // Discrete front end: no timing of its own, so any glitch shows through
    assign pa_on_out  = tx_en_in;
    assign lna_on_out = rx_en_in & ~tx_en_in;
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rfs_pkg::*;
    logic       clk;
    logic       rst_n;
    logic       r_tx;
    logic       r_rx;
    logic       sck;
    logic       cs_n;
    logic       mosi;
    logic       miso;
    logic       fe_tx;
    logic       fe_rx;
    logic [1:0] lead;
    logic       pa_on;
    logic       lna_on;
    logic [7:0] rd;
    int         fails;
    int         n_tests;

    rfs_front_end i_rfs_front_end (
        .REF_CLK_IN            (clk),
        .RESET_N_IN            (rst_n),
        .RADIO_TX_IN           (r_tx),
        .RADIO_RX_IN           (r_rx),
        .SPI_SCK_IN            (sck),
        .SPI_CS_N_IN           (cs_n),
        .SPI_MOSI_IN           (mosi),
        .SPI_MISO_OUT          (miso),
        .FRONT_END_TX_LINE_OUT (fe_tx),
        .FRONT_END_RX_LINE_OUT (fe_rx),
        .AMP_LEAD_TIME_OUT     (lead)
    );
    rfs_fe_model i_rfs_fe_model (
        .tx_en_in   (fe_tx),
        .rx_en_in   (fe_rx),
        .pa_on_out  (pa_on),
        .lna_on_out (lna_on)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // SCK phases of four clocks keep well clear of the synchroniser
    task automatic spi(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] s;
        s = {a, d};
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = s[i];
            tick(4);
            if (i < 8) rd[i] = miso;
            sck = 1'b1;
            tick(4);
            sck = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        mosi = ~mosi;
        tick(4);
    endtask

    task automatic fe(input logic t, input logic r, input logic [1:0] e);
        logic [7:0] seen_v;
        r_tx = t;
        r_rx = r;
        tick(4);
        seen_v = {4'h0, pa_on, lna_on, fe_tx, fe_rx};
        check(seen_v, {4'h0, e, e});
    endtask

    task automatic t_reset();
        spi(TRX_CTRL_ONE_ADDR | READ_BIT_MASK, 8'h00);
        check(rd, TRX_CTRL_ONE_RST);
        check({6'h0, lead}, 8'h00);
        fe(1'b1, 1'b0, 2'h0);
        fe(1'b0, 1'b1, 2'h0);
    endtask

    task automatic t_modes();
        spi(TRX_CTRL_ONE_ADDR, 8'h80);
        spi(TRX_CTRL_ONE_ADDR | READ_BIT_MASK, 8'h00);
        check(rd, 8'h80);
        fe(1'b1, 1'b0, 2'h2);
        fe(1'b0, 1'b1, 2'h1);
        fe(1'b1, 1'b1, 2'h2);
        fe(1'b0, 1'b0, 2'h0);
    endtask

    task automatic t_lead();
        spi(RF_CTRL_ZERO_ADDR, {6'h0, LEAD_MAX});
        check({6'h0, lead}, {6'h0, LEAD_MAX});
        spi(RF_CTRL_ZERO_ADDR | READ_BIT_MASK, 8'h00);
        check(rd, 8'h03);
        spi(8'h8a, 8'h00);
        check(rd, 8'h00);
    endtask

    task automatic t_sleep();
        fe(1'b1, 1'b0, 2'h2);
        spi(TRX_CTRL_ONE_ADDR, 8'h00);
        fe(1'b1, 1'b0, 2'h0);
        fe(1'b0, 1'b1, 2'h0);
        spi(TRX_CTRL_ONE_ADDR, 8'h80);
        fe(1'b0, 1'b1, 2'h1);
    endtask

    // Mid-run reset must clear both registers and the lines
    task automatic t_rereset();
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(4);
        check({6'h0, lead}, 8'h00);
        spi(TRX_CTRL_ONE_ADDR | READ_BIT_MASK, 8'h00);
        check(rd, TRX_CTRL_ONE_RST);
        fe(1'b1, 1'b0, 2'h0);
    endtask

    task automatic wrap_up();
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        fails = 0;
        n_tests = 0;
        rst_n = 1'b0;
        r_tx = 1'b0;
        r_rx = 1'b0;
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        rd = 8'h00;
        tick(16);
        rst_n = 1'b1;
        tick(4);
        t_reset();
        t_modes();
        t_lead();
        t_sleep();
        t_rereset();
        wrap_up();
    end

    // Nine frames of some 140 clocks each; allow ample margin
    initial begin
        #500us;
        fails++;
        wrap_up();
    end
endmodule
